// *** rtl/index_pointer_addressing.sv ***
// Module: accumulator and index pointer of the controller core, with
// memory-mapped pointer bytes and indexed address generation.
// Assumes: the core's execution unit issues at most one request of each
// kind per cycle, synchronous to ref_clk_i.
// Operation
// - Eight-bit accumulator holds operands and results.
// - Effective address is pointer plus unsigned offset.
// - Indexed writes never modify program space.
// - Pointer instruction loads all twelve bits.
// - Pointer bytes mapped at 0xBE and 0xBF.
// - Lower eleven bits address the selected space; data space uses only the low eight bits of the sum.
// - Bit eleven write-only, selects the space.
// - Select 0 data 0x000-0x0FF, 1 program 0x800-0xFFF.
// - Counter use changes only lower eleven bits.
// - Pointer mapped; accumulator never memory-mapped.
`timescale 1ns/1ps
module index_pointer_addressing
	import ipa_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_i,
	// Accumulator
	input  wire logic                 acc_we_i,
	input  wire logic [ACC_W-1:0]     acc_d_i,
	output logic      [ACC_W-1:0]     acc_q_o,
	// Pointer instructions
	input  wire logic                 ptr_load_i,
	input  wire logic [PTR_W-1:0]     ptr_d_i,
	input  wire logic                 ptr_inc_i,
	input  wire logic                 ptr_dec_i,
	output logic      [PTR_W-1:0]     ptr_q_o,
	// Memory-mapped access
	input  wire logic                 mm_re_i,
	input  wire logic                 mm_we_i,
	input  wire logic [MM_ADDR_W-1:0] mm_addr_i,
	input  wire logic [DATA_W-1:0]    mm_wdata_i,
	output logic      [DATA_W-1:0]    mm_rdata_o,
	output logic                      mm_ack_o,
	// Indexed access
	input  wire logic                 idx_req_i,
	input  wire logic                 idx_we_i,
	input  wire logic [OFF_W-1:0]     idx_off_i,
	input  wire logic [DATA_W-1:0]    idx_wdata_i,
	output logic      [PTR_W-1:0]     ea_o,
	output logic                      data_re_o,
	output logic                      data_we_o,
	output logic                      prog_re_o,
	output logic      [DATA_W-1:0]    wdata_o,
	output logic                      wr_blocked_o
);
	// ==========================================================
	// Address generator
	ea_if eif ();

	ea_gen u_ea_gen (
		.eif (eif.gen)
	);

	// ==========================================================
	// Register state
	logic [ACC_W-1:0]  acc_r,   acc_nxt;
	logic [PTR_W-1:0]  ptr_r,   ptr_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic              ack_r,   ack_nxt;
	logic [PTR_W-1:0]  ea_r,    ea_nxt;
	logic              dre_r,   dre_nxt;
	logic              dwe_r,   dwe_nxt;
	logic              pre_r,   pre_nxt;
	logic [DATA_W-1:0] wd_r,    wd_nxt;
	logic              blk_r,   blk_nxt;
	logic              hit_high;
	logic              hit_low;

	// Pointer and offset feed the address generator.
	assign eif.ptr    = ptr_r;
	assign eif.offset = idx_off_i;

	// Only the two pointer bytes are claimed; the accumulator has no address.
	assign hit_high = (mm_addr_i == INDEX_POINTER_HIGH_ADDR);
	assign hit_low  = (mm_addr_i == INDEX_POINTER_LOW_ADDR);

	// Next values for accumulator, pointer, read port and indexed strobes.
	always_comb begin
		acc_nxt = acc_r;
		if (acc_we_i) begin
			acc_nxt = acc_d_i;
		end
		// Load beats a mapped write, which beats counting.
		ptr_nxt = ptr_r;
		if (ptr_load_i) begin
			ptr_nxt = ptr_d_i;
		end else if (mm_we_i && hit_high) begin
			ptr_nxt[HIGH_MSB:HIGH_LSB] =
				mm_wdata_i[HIGH_W-1:0];
		end else if (mm_we_i && hit_low) begin
			ptr_nxt[LOW_MSB:0] = mm_wdata_i;
		end else if (ptr_inc_i) begin
			ptr_nxt[LOW_W-1:0] = ptr_r[LOW_W-1:0] + 11'h001;
		end else if (ptr_dec_i) begin
			ptr_nxt[LOW_W-1:0] = ptr_r[LOW_W-1:0] - 11'h001;
		end
		// Readback hides the select bit, which software cannot read.
		rdata_nxt = RDATA_IDLE;
		ack_nxt   = 1'b0;
		if (mm_re_i && hit_high) begin
			rdata_nxt = {5'h00, ptr_r[SEL_BIT-1:HIGH_LSB]};
			ack_nxt   = 1'b1;
		end else if (mm_re_i && hit_low) begin
			rdata_nxt = ptr_r[LOW_MSB:0];
			ack_nxt   = 1'b1;
		end
		// Indexed strobes by space; program writes are dropped.
		ea_nxt  = ea_r;
		dre_nxt = 1'b0;
		dwe_nxt = 1'b0;
		pre_nxt = 1'b0;
		blk_nxt = 1'b0;
		wd_nxt  = wd_r;
		if (idx_req_i) begin
			ea_nxt = eif.ea;
			wd_nxt = idx_wdata_i;
			if (eif.prog_sel) begin
				pre_nxt = !idx_we_i;
				blk_nxt = idx_we_i;
			end else begin
				dre_nxt = !idx_we_i;
				dwe_nxt = idx_we_i;
			end
		end
	end

	// Register all state.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			acc_r   <= ACC_RST;
			ptr_r   <= PTR_RST;
			rdata_r <= RDATA_IDLE;
			ack_r   <= 1'b0;
			ea_r    <= PTR_RST;
			dre_r   <= 1'b0;
			dwe_r   <= 1'b0;
			pre_r   <= 1'b0;
			wd_r    <= RDATA_IDLE;
			blk_r   <= 1'b0;
		end else begin
			acc_r   <= acc_nxt;
			ptr_r   <= ptr_nxt;
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
			ea_r    <= ea_nxt;
			dre_r   <= dre_nxt;
			dwe_r   <= dwe_nxt;
			pre_r   <= pre_nxt;
			wd_r    <= wd_nxt;
			blk_r   <= blk_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign acc_q_o      = acc_r;
	assign ptr_q_o      = ptr_r;
	assign mm_rdata_o   = rdata_r;
	assign mm_ack_o     = ack_r;
	assign ea_o         = ea_r;
	assign data_re_o    = dre_r;
	assign data_we_o    = dwe_r;
	assign prog_re_o    = pre_r;
	assign wdata_o      = wd_r;
	assign wr_blocked_o = blk_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// Accumulator takes the written byte one cycle later.
	acc_load_a: assert property (
		acc_we_i |=> acc_q_o == $past(acc_d_i))
		else $error("accumulator did not load");

	// Program-space address is select plus wrapped eleven-bit sum.
	prog_ea_a: assert property (
		idx_req_i && ptr_r[SEL_BIT] |=>
		ea_o == {1'b1, 11'($past(ptr_r[10:0]) + $past(idx_off_i))})
		else $error("wrong program effective address");

	// A write through the pointer into program space raises wr_blocked_o, not data_we_o or prog_re_o.
	prog_ro_a: assert property (
		idx_req_i && idx_we_i && ptr_r[SEL_BIT] |=>
		!data_we_o && wr_blocked_o && !prog_re_o)
		else $error("program space was written");

	// Pointer instruction loads the full twelve bits.
	ptr_load_a: assert property (
		ptr_load_i |=> ptr_q_o == $past(ptr_d_i))
		else $error("pointer load failed");

	// High byte reads back bits 10..8 with the select bit hidden.
	high_read_a: assert property (
		mm_re_i && hit_high |=>
		mm_ack_o && mm_rdata_o == {5'h00, $past(ptr_r[10:8])})
		else $error("high byte readback wrong");

	// Low byte write lands in bits 7..0 unless a load overrides it.
	low_write_a: assert property (
		mm_we_i && hit_low && !ptr_load_i |=>
		ptr_q_o[7:0] == $past(mm_wdata_i)
		&& ptr_q_o[11:8] == $past(ptr_r[11:8]))
		else $error("low byte write wrong");

	// Data strobes stay in the data window, program reads in the upper.
	space_range_a: assert property (
		(data_re_o || data_we_o) |-> ea_o <= DATA_SPACE_LAST)
		else $error("data access out of range");
	prog_range_a: assert property (
		prog_re_o |-> ea_o >= PROG_SPACE_FIRST)
		else $error("program access out of range");

	// Incrementing moves only the lower eleven bits and keeps the select.
	count_sel_a: assert property (
		ptr_inc_i && !ptr_load_i && !mm_we_i |=>
		ptr_q_o[11] == $past(ptr_r[11])
		&& ptr_q_o[10:0] == 11'($past(ptr_r[10:0]) + 11'h001))
		else $error("pointer count disturbed select");

	// Other addresses are never acknowledged here.
	unmapped_a: assert property (
		mm_re_i && !hit_high && !hit_low |=> !mm_ack_o)
		else $error("unmapped address acknowledged");

	// Main scenarios.
	prog_read_c: cover property (idx_req_i && !idx_we_i
		&& ptr_r[SEL_BIT] ##1 prog_re_o);
	blocked_c: cover property (wr_blocked_o);
	wrap_c: cover property (ptr_inc_i && ptr_r[10:0] == 11'h7FF);
	high_rd_c: cover property (mm_re_i && hit_high ##1 mm_ack_o);
endmodule : index_pointer_addressing

// *** rtl/ipa_pkg.sv ***
// Package: constants shared by the index pointer block and its address
// generator.
// Assumes: one clock domain; the core drives all requests synchronously.
package ipa_pkg;
	// ==========================================================
	// Widths
	localparam int ACC_W      = 8;   // Accumulator width.
	localparam int PTR_W      = 12;  // Full index pointer width.
	localparam int LOW_W      = 11;  // Address part of the pointer.
	localparam int OFF_W      = 8;   // Indexed-mode offset width.
	localparam int MM_ADDR_W  = 8;   // Memory-mapped data address width.
	localparam int DATA_W     = 8;   // Memory-mapped data width.
	localparam int HIGH_W     = 4;   // Width of the high pointer byte field.
	// ==========================================================
	// Field positions
	localparam int SEL_BIT    = 11;  // Space-select bit of the pointer.
	localparam int HIGH_MSB   = 11;  // High field spans 11..8.
	localparam int HIGH_LSB   = 8;
	localparam int LOW_MSB    = 7;   // Low field spans 7..0.
	localparam int DSPACE_W   = 8;   // Data space is 256 bytes.
	// ==========================================================
	// Memory-mapped offsets
	localparam logic [MM_ADDR_W-1:0] INDEX_POINTER_HIGH_ADDR = 8'hBE;
	localparam logic [MM_ADDR_W-1:0] INDEX_POINTER_LOW_ADDR  = 8'hBF;
	// ==========================================================
	// Reset values and space limits
	localparam logic [ACC_W-1:0]  ACC_RST      = 8'h00;
	localparam logic [PTR_W-1:0]  PTR_RST      = 12'h000;
	localparam logic [DATA_W-1:0] RDATA_IDLE   = 8'h00;
	localparam logic [PTR_W-1:0]  DATA_SPACE_LAST  = 12'h0FF;
	localparam logic [PTR_W-1:0]  PROG_SPACE_FIRST = 12'h800;
endpackage : ipa_pkg

// *** rtl/ea_if.sv ***
// Interface: carries pointer and offset to the address generator and
// brings the effective address back.
// Assumes: purely combinational traffic inside one clock domain.
`timescale 1ns/1ps
interface ea_if;
	import ipa_pkg::*;
	logic [PTR_W-1:0] ptr;
	logic [OFF_W-1:0] offset;
	logic [PTR_W-1:0] ea;
	logic             prog_sel;
	modport core (output ptr, output offset, input ea, input prog_sel);
	modport gen  (input ptr, input offset, output ea, output prog_sel);
endinterface : ea_if

// *** rtl/ea_gen.sv ***
// Module: effective address generator for indexed accesses.
// Assumes: the caller registers the result; this module is combinational.
`timescale 1ns/1ps
module ea_gen
	import ipa_pkg::*;
(
	// Pointer and offset in, address out
	ea_if.gen eif
);
	// ==========================================================
	// Address formation
	logic [LOW_W-1:0] sum;

	// Offset is unsigned and the sum wraps inside the address bits.
	always_comb begin
		sum = eif.ptr[LOW_W-1:0]
			+ {{(LOW_W-OFF_W){1'b0}}, eif.offset};
		eif.prog_sel = eif.ptr[SEL_BIT];
		if (eif.prog_sel) begin
			// Program space: upper half of the map.
			eif.ea = {1'b1, sum};
		end else begin
			// Data space: only the low 256 bytes exist.
			eif.ea = {{(PTR_W-DSPACE_W){1'b0}},
				sum[DSPACE_W-1:0]};
		end
	end
endmodule : ea_gen

// *** dv/core_mem_model.sv ***
// Partner model: data memory of the core behind the indexed strobes.
// Assumes: strobes are one-cycle pulses synchronous to ref_clk_i.
`timescale 1ns/1ps
module core_mem_model (
	// Strobes from the block
	input  wire logic        ref_clk_i,
	input  wire logic        data_we_i,
	input  wire logic [11:0] ea_i,
	input  wire logic [7:0]  wdata_i,
	// Bench peek port
	input  wire logic [7:0]  peek_i,
	output logic      [7:0]  peek_o
);
	// ======
	// Storage
	// Only data space is held, so a program write can never land here.
	logic [7:0] mem_r [256];
	// Captures a data write while its strobe stands.
	always @(posedge ref_clk_i) begin
		if (data_we_i === 1'b1) begin
			mem_r[ea_i[7:0]] <= wdata_i;
		end
	end
	assign peek_o = mem_r[peek_i];
endmodule : core_mem_model

// *** dv/index_pointer_addressing_test.sv ***
// Testbench of the index pointer block with a core memory model.
// Assumes: ipa_pkg is compiled first; one 25 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t exp %h got %h", $time, (e), (g)); end end
module index_pointer_addressing_test;
	import ipa_pkg::*;
	// ======
	// Signals
	// Request bits: idx_we, acc_we, load, inc, dec, mm_re, mm_we, idx.
	localparam logic [7:0] ACC = 8'h40, LD = 8'h20, INC = 8'h10;
	localparam logic [7:0] DEC = 8'h08, RD = 8'h04, WR = 8'h02;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  req = 8'h00;
	logic [11:0] a = 12'h000;
	logic [7:0]  d = 8'h00;
	logic [7:0]  seed = 8'h12;
	logic [7:0]  acc_q_o, mm_rdata_o, wdata_o, peek, peek_q;
	logic [11:0] ptr_q_o, ea_o, p;
	logic        mm_ack_o, data_re_o, data_we_o, prog_re_o, wr_blocked_o;
	logic [11:0] pt [4] = '{12'h805, 12'h7F0, 12'hFF0, 12'h0FF};
	logic [24:0] q [$];
	logic [24:0] obs;
	int          failures = 0;
	int          checked = 0;
	int          cycles = 0;
	index_pointer_addressing index_pointer_addressing_i (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.acc_we_i(req[6]), .acc_d_i(d), .acc_q_o(acc_q_o),
		.ptr_load_i(req[5]), .ptr_d_i(a), .ptr_inc_i(req[4]),
		.ptr_dec_i(req[3]), .ptr_q_o(ptr_q_o),
		.mm_re_i(req[2]), .mm_we_i(req[1]), .mm_addr_i(a[7:0]),
		.mm_wdata_i(d), .mm_rdata_o(mm_rdata_o), .mm_ack_o(mm_ack_o),
		.idx_req_i(req[0]), .idx_we_i(req[7]), .idx_off_i(a[7:0]),
		.idx_wdata_i(d), .ea_o(ea_o), .data_re_o(data_re_o),
		.data_we_o(data_we_o), .prog_re_o(prog_re_o),
		.wdata_o(wdata_o), .wr_blocked_o(wr_blocked_o));
	core_mem_model core_mem_model_i (.ref_clk_i(ref_clk_i),
		.data_we_i(data_we_o), .ea_i(ea_o), .wdata_i(wdata_o),
		.peek_i(peek), .peek_o(peek_q));
	// Makes the 40 ns clock.
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// ======
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Sum wraps in eleven bits; data space keeps only eight of them.
	function automatic logic [11:0] ea_of(input logic [11:0] pv,
		input logic [7:0] o);
		logic [10:0] s;
		s = pv[10:0] + {3'h0, o};
		return pv[11] ? {1'b1, s} : {4'h0, s[7:0]};
	endfunction : ea_of
	// Holds one request for one edge, then releases it.
	task automatic pulse(input logic [7:0] r, input logic [11:0] av,
		input logic [7:0] dv);
		@(posedge ref_clk_i);
		req <= r;
		a <= av;
		d <= dv;
		@(posedge ref_clk_i);
		req <= 8'h00;
		#1;
	endtask : pulse
	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// ======
	// Monitor and watchdog
	// Takes the oldest note whenever a strobe or acknowledge appears.
	always @(negedge ref_clk_i) begin
		if (!rst_i && (|{data_re_o, data_we_o, prog_re_o, wr_blocked_o,
			mm_ack_o}) === 1'b1) begin
			obs = {data_re_o, data_we_o, prog_re_o, wr_blocked_o, mm_ack_o,
				mm_ack_o ? mm_rdata_o : (data_we_o ? wdata_o : 8'h00),
				(mm_ack_o | wr_blocked_o) ? 12'h000 : ea_o};
			if (q.size() == 0) begin
				`CHK(obs, 25'h0)
			end else begin
				`CHK(obs, q.pop_front())
			end
		end
	end
	// Cuts a hang short.
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			wrap_up();
		end
	end
	// ======
	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK(ptr_q_o, 12'h000)
		repeat (4) begin
			seed = lfsr(seed);
			pulse(ACC, 12'h000, seed);
			`CHK(acc_q_o, seed)
		end
		// Indexed reads and writes in both spaces, with wrapping sums.
		foreach (pt[i]) begin
			for (int w = 0; w < 2; w++) begin
				seed = lfsr(seed);
				pulse(LD, pt[i], 8'h00);
				`CHK(ptr_q_o, pt[i])
				p = ea_of(pt[i], seed);
				q.push_back({w ? (pt[i][11] ? 5'h02 : 5'h08) :
					(pt[i][11] ? 5'h04 : 5'h10),
					(w && !pt[i][11]) ? ~seed : 8'h00,
					(w && pt[i][11]) ? 12'h000 : p});
				pulse({w[0], 7'h01}, {4'h0, seed}, ~seed);
				peek = p[7:0];
				@(posedge ref_clk_i);
				#1;
				if (w && !pt[i][11]) `CHK(peek_q, ~seed)
			end
		end
		// Mapped bytes; the select bit reads back as zero.
		pulse(WR, {4'h0, INDEX_POINTER_HIGH_ADDR}, 8'hFF);
		pulse(WR, {4'h0, INDEX_POINTER_LOW_ADDR}, 8'hA5);
		`CHK(ptr_q_o, 12'hFA5)
		q.push_back({5'h01, 8'h07, 12'h000});
		pulse(RD, {4'h0, INDEX_POINTER_HIGH_ADDR}, 8'h00);
		q.push_back({5'h01, 8'hA5, 12'h000});
		pulse(RD, {4'h0, INDEX_POINTER_LOW_ADDR}, 8'h00);
		pulse(RD, 12'h0BD, 8'h00);
		// Counting keeps the select bit.
		pulse(LD, 12'hFFF, 8'h00);
		pulse(INC, 12'h000, 8'h00);
		`CHK(ptr_q_o, 12'h800)
		pulse(DEC, 12'h000, 8'h00);
		`CHK(ptr_q_o, 12'hFFF)
		pulse(LD | INC, 12'h123, 8'h00);
		`CHK(ptr_q_o, 12'h123)
		repeat (2) @(posedge ref_clk_i);
		`CHK(q.size(), 0)
		wrap_up();
	end
endmodule : index_pointer_addressing_test
